// ===== hdl/wdg_top.sv
/*
 watchdog with reset flags: apb register file, kick modes, halt/time-out
 flags, chip/warm reset requests, interrupt.
 assumes core strobes are one-cycle pulses on pclk; wdg_osc is async.
*/
`timescale 1ns/10ps
`include "wdg_map.svh"
module wdg_top
   import wdg_pkg::*;
(
   input  wire logic        pclk,             // 100 MHz clock
   input  wire logic        presetn,          // power-up reset, active low
   input  wire logic        ce,               // clock enable
   input  wire logic        psel,             // apb select
   input  wire logic        penable,          // apb enable
   input  wire logic        pwrite,           // apb write
   input  wire logic [11:0] paddr,            // apb byte address
   input  wire logic [31:0] pwdata,           // apb write data
   output logic      [31:0] prdata,           // apb read data
   output logic             pready,           // apb ready
   output logic             pslverr,          // apb error
   input  wire logic        external_clear_n, // reset pin, async
   input  wire logic        wdg_osc,          // rc oscillator, async
   input  wire logic        kick_single,      // single kick strobe
   input  wire logic        kick_first,       // first kick strobe
   input  wire logic        kick_second,      // second kick strobe
   input  wire logic        halt_exec,        // halt instruction strobe
   input  wire logic        wake,             // wake-up from halt
   input  wire logic [3:0]  alu_flags,        // ov z ac c from core
   input  wire logic        alu_flags_we,     // core flag update
   output logic             chip_reset,       // chip reset pulse
   output logic             warm_reset,       // pc/stack pointer clear pulse
   output logic             sys_clk_stop,     // system clock gated off
   output logic             irq               // interrupt level
);
   logic [7:0] prescale_sel;
   logic [7:0] status_low;
   logic       powerdown_flag;
   logic       expiry_flag;
   logic [7:0] cfg;
   logic [1:0] irq_stat;
   logic [1:0] irq_mask;
   logic       halted;
   logic       rst_pin_s;
   logic       osc_s;
   logic       osc_d;
   logic [1:0] idiv;
   logic       tick;
   logic       expire;
   logic       kick_eff;
   logic       chain_clear;
   logic       pin_clear;
   wdg_pair_t  pair_st;

   function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
      hit = (a == off);
   endfunction

   wire wr_en = psel && penable && pwrite && ce;
   wire rd_en = psel && penable && !pwrite && ce;
   wire en    = cfg[`WDG_CFG_ENABLE];
   wire paired = cfg[`WDG_CFG_PAIRED];

   wdg_sync u_sync_rst
   (
      .pclk    (pclk),
      .presetn (presetn),
      .ce      (ce),
      .d       (!external_clear_n),
      .q       (rst_pin_s)
   );

   wdg_sync u_sync_osc
   (
      .pclk    (pclk),
      .presetn (presetn),
      .ce      (ce),
      .d       (wdg_osc),
      .q       (osc_s)
   );

   // pin synced active high: flop reset value means released, no clear after power-up
   assign pin_clear = rst_pin_s;

   // source tick: rc edge, or every 4th pclk while running
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         osc_d <= 1'b0;
         idiv  <= 2'b00;
      end
      else if (ce)
      begin
         osc_d <= osc_s;
         if (!halted)
            idiv <= idiv + 2'b01;
      end
   end

   always_comb
   begin
      if (cfg[`WDG_CFG_SRC_INSTR])
         tick = !halted && (idiv == 2'(`WDG_INSTR_DIV - 1));
      else
         tick = osc_s && !osc_d;
   end

   // kick decode
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         pair_st <= WDG_PAIR_IDLE;
      else if (ce)
      begin
         if (!en || !paired || pin_clear || halt_exec)
            pair_st <= WDG_PAIR_IDLE;
         else
         begin
            unique case (pair_st)
               WDG_PAIR_IDLE: if (kick_first) pair_st <= WDG_PAIR_HALF;
               WDG_PAIR_HALF: if (kick_second) pair_st <= WDG_PAIR_IDLE;
               default:       pair_st <= WDG_PAIR_IDLE;
            endcase
         end
      end
   end

   always_comb
   begin
      kick_eff = 1'b0;
      if (en)
      begin
         if (!paired)
            kick_eff = kick_single;
         else
            kick_eff = (pair_st == WDG_PAIR_HALF) && kick_second;
      end
   end

   assign chain_clear = pin_clear || kick_eff || (en && halt_exec);

   wdg_counter u_counter
   (
      .pclk    (pclk),
      .presetn (presetn),
      .ce      (ce),
      .tick    (tick && en),
      .clear   (chain_clear),
      .sel     (prescale_sel[`WDG_SEL_MSB:0]),
      .expire  (expire)
   );

   wire exp_ev = en && expire && !chain_clear;

   // halt state: system clock stopped until wake, external clear or time-out
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         halted <= 1'b0;
      else if (ce)
      begin
         if (halt_exec)
            halted <= 1'b1;
         else if (wake || pin_clear || exp_ev)
            halted <= 1'b0;
      end
   end
   assign sys_clk_stop = halted;

   // reset requests
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         chip_reset <= 1'b0;
         warm_reset <= 1'b0;
      end
      else if (ce)
      begin
         chip_reset <= exp_ev && !halted;
         warm_reset <= exp_ev && halted;
      end
   end

   // watchdog flags
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         powerdown_flag <= 1'b0;
         expiry_flag    <= 1'b0;
      end
      else if (ce && en)
      begin
         if (exp_ev)
            expiry_flag <= 1'b1;
         else if (kick_eff || halt_exec)
            expiry_flag <= 1'b0;
         if (halt_exec)
            powerdown_flag <= 1'b1;
         else if (kick_eff)
            powerdown_flag <= 1'b0;
      end
   end

   // alu flags and software writes
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         status_low <= 8'h00;
      else if (ce)
      begin
         if (wr_en && hit(paddr, `WDG_OFF_STATUS))
            status_low <= pwdata[7:0] & `WDG_STATUS_WMASK;
         else if (alu_flags_we)
            status_low <= {4'h0, alu_flags};
      end
   end

   // select register, reset on chip reset but kept on warm reset
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         prescale_sel <= `WDG_PRESCALE_RST;
      else if (ce)
      begin
         if (pin_clear || chip_reset)
            prescale_sel <= `WDG_PRESCALE_RST;
         else if (wr_en && hit(paddr, `WDG_OFF_PRESCALE))
            prescale_sel <= pwdata[7:0];
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         cfg      <= `WDG_CFG_RST;
         irq_mask <= 2'b00;
      end
      else if (ce && wr_en)
      begin
         if (hit(paddr, `WDG_OFF_CONFIG))
            cfg <= {5'h00, pwdata[2:0]};
         if (hit(paddr, `WDG_OFF_IRQ_MASK))
            irq_mask <= pwdata[1:0];
      end
   end

   // sticky events, read clears, set wins
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         irq_stat <= 2'b00;
      else if (ce)
      begin
         logic [1:0] nset;
         nset = {exp_ev && halted, exp_ev && !halted};
         // clear only what the setup cycle reported
         if (rd_en && hit(paddr, `WDG_OFF_IRQ_STAT))
            irq_stat <= (irq_stat & ~prdata[1:0]) | nset;
         else
            irq_stat <= irq_stat | nset;
      end
   end
   assign irq = |(irq_stat & irq_mask);

   wire [7:0] status_rd = {2'b00, expiry_flag, powerdown_flag,
                           status_low[3:0]};

   assign pready = 1'b1;

   always_comb
   begin
      pslverr = 1'b0;
      unique case (paddr)
         `WDG_OFF_PRESCALE, `WDG_OFF_STATUS, `WDG_OFF_IRQ_STAT,
         `WDG_OFF_IRQ_MASK, `WDG_OFF_CONFIG, `WDG_OFF_CORE_STATE: ;
         default: pslverr = psel && penable;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         prdata <= 32'h0000_0000;
      else if (ce && psel && !penable && !pwrite)
      begin
         unique case (paddr)
            `WDG_OFF_PRESCALE:   prdata <= {24'h0, prescale_sel};
            `WDG_OFF_STATUS:     prdata <= {24'h0, status_rd};
            `WDG_OFF_IRQ_STAT:   prdata <= {30'h0, irq_stat};
            `WDG_OFF_IRQ_MASK:   prdata <= {30'h0, irq_mask};
            `WDG_OFF_CONFIG:     prdata <= {24'h0, cfg};
            `WDG_OFF_CORE_STATE: prdata <= {29'h0, pair_st == WDG_PAIR_HALF, halted, en};
            default:             prdata <= 32'h0000_0000;
         endcase
      end
   end

   chk_halt_sets_pdf: assert property (@(posedge pclk) disable iff (!presetn)
      ce && en && halt_exec |=> powerdown_flag && !expiry_flag)
      else $error("halt did not set powerdown flag");
   chk_kick_clears_pdf: assert property (@(posedge pclk) disable iff (!presetn)
      ce && kick_eff && !halt_exec |=> !powerdown_flag)
      else $error("kick did not clear powerdown flag");
   chk_timeout_sets_to: assert property (@(posedge pclk) disable iff (!presetn)
      ce && en && exp_ev |=> expiry_flag)
      else $error("time-out did not set expiry flag");
   chk_chip_reset_cause: assert property (@(posedge pclk) disable iff (!presetn)
      ce && exp_ev && !halted |=> chip_reset && !warm_reset)
      else $error("normal overflow missing chip reset");
   chk_warm_reset_cause: assert property (@(posedge pclk) disable iff (!presetn)
      ce && exp_ev && halted |=> warm_reset && !chip_reset)
      else $error("halted overflow missing warm reset");
   chk_disabled_no_kick: assert property (@(posedge pclk) disable iff (!presetn)
      !en |-> !kick_eff ##1 ($stable(powerdown_flag) && $stable(expiry_flag)))
      else $error("kick acted while disabled");
   chk_status_write_keep: assert property (@(posedge pclk) disable iff (!presetn)
      ce && wr_en && hit(paddr, `WDG_OFF_STATUS) && !kick_eff && !halt_exec && !exp_ev
      |=> $stable(expiry_flag) && $stable(powerdown_flag))
      else $error("status write changed watchdog flags");
   chk_top_bits_zero: assert property (@(posedge pclk) disable iff (!presetn)
      ce && psel && !penable && !pwrite && hit(paddr, `WDG_OFF_STATUS)
      |=> prdata[7:6] == 2'b00)
      else $error("status bits 7..6 not zero");
   chk_single_mode_ignore: assert property (@(posedge pclk) disable iff (!presetn)
      ce && en && !paired && (kick_first || kick_second) && !kick_single |-> !kick_eff)
      else $error("paired kick acted in single mode");
   chk_instr_halt_stop: assert property (@(posedge pclk) disable iff (!presetn)
      cfg[`WDG_CFG_SRC_INSTR] && halted |-> !tick)
      else $error("instruction source ticked while halted");

   cov_chip_reset: cover property (@(posedge pclk) chip_reset);
   cov_warm_reset: cover property (@(posedge pclk) warm_reset);
   cov_paired_kick: cover property (@(posedge pclk) paired && kick_eff);
   cov_irq: cover property (@(posedge pclk) irq);
endmodule // wdg_top

// ===== hdl/wdg_map.svh
/*
 watchdog register map, field positions, reset values and timing counts.
 assumes inclusion by the design modules; the watchdog package does not include it.
*/
`ifndef WDG_MAP_SVH
`define WDG_MAP_SVH
`define WDG_OFF_PRESCALE   12'h024
`define WDG_OFF_STATUS     12'h028
`define WDG_OFF_IRQ_STAT   12'h040
`define WDG_OFF_IRQ_MASK   12'h044
`define WDG_OFF_CONFIG     12'h048
`define WDG_OFF_CORE_STATE 12'h04C
`define WDG_IDX_PRESCALE   8'h09
`define WDG_IDX_STATUS     8'h0A
`define WDG_PRESCALE_RST   8'h07
`define WDG_SEL_MSB        2
`define WDG_PDF_BIT        4
`define WDG_TO_BIT         5
`define WDG_STATUS_WMASK   8'h0F
`define WDG_BASE_DIV_BITS  9
`define WDG_INSTR_DIV      4
`define WDG_CFG_RST        8'h01
`define WDG_CFG_ENABLE     0
`define WDG_CFG_SRC_INSTR  1
`define WDG_CFG_PAIRED     2
`define WDG_IRQ_CHIP       0
`define WDG_IRQ_WARM       1
`endif

// ===== hdl/wdg_pkg.sv
/*
 watchdog types: state of the paired-kick sequence.
 assumes nothing beyond the map header.
*/
package wdg_pkg;
   typedef enum logic [1:0] {
      WDG_PAIR_IDLE = 2'b01,
      WDG_PAIR_HALF = 2'b10
   } wdg_pair_t;
endpackage

// ===== hdl/wdg_sync.sv
/*
 two-flop synchroniser for the watchdog oscillator and the reset pin.
 assumes an asynchronous source, pclk destination.
*/
`timescale 1ns/10ps
module wdg_sync
(
   input  wire logic pclk,     // clock
   input  wire logic presetn,  // async reset
   input  wire logic ce,       // clock enable
   input  wire logic d,        // async level
   output logic      q         // synced level
);
   logic meta;
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         meta <= 1'b0;
         q    <= 1'b0;
      end
      else if (ce)
      begin
         meta <= d;
         q    <= meta;
      end
   end
endmodule // wdg_sync

// ===== hdl/wdg_counter.sv
/*
 watchdog count chain: 9-stage base divider then 7-bit prescaler.
 assumes one-cycle tick pulses and a synchronous clear.
*/
`timescale 1ns/10ps
`include "wdg_map.svh"
module wdg_counter
   import wdg_pkg::*;
(
   input  wire logic       pclk,     // clock
   input  wire logic       presetn,  // async reset
   input  wire logic       ce,       // clock enable
   input  wire logic       tick,     // source tick
   input  wire logic       clear,    // clear chain
   input  wire logic [2:0] sel,      // prescale code
   output logic            expire    // overflow pulse
);
   localparam int CW = `WDG_BASE_DIV_BITS + 7;
   logic [CW-1:0] cnt;
   logic [CW-1:0] limit;
   // full count = 512 * 2^sel source ticks
   always_comb limit = CW'((32'd1 << (`WDG_BASE_DIV_BITS + 32'(sel))) - 32'd1);
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         cnt    <= '0;
         expire <= 1'b0;
      end
      else if (ce)
      begin
         expire <= 1'b0;
         if (clear)
            cnt <= '0;
         else if (tick)
         begin
            if (cnt >= limit)
            begin
               cnt    <= '0;
               expire <= 1'b1;
            end
            else
               cnt <= cnt + CW'(1);
         end
      end
   end
endmodule // wdg_counter

// ===== tb/tb_top.sv
/*
 self-checking bench for the watchdog block: register table, time-out
 periods, kick modes, halt and flags, external clear, interrupt.
 assumes wdg_top with zero-wait apb and one-cycle core strobes.
*/
`timescale 1ns/10ps
module tb_top;
   import wdg_pkg::*;
   typedef struct packed {logic [11:0] a; logic [31:0] d; logic [31:0] e; logic err;} wdg_row_t;
   logic        pclk = 1'b0, presetn = 1'b0, ce = 1'b1, psel = 1'b0, penable = 1'b0;
   logic        pwrite = 1'b0, external_clear_n = 1'b1, wdg_osc = 1'b0;
   logic [5:0]  stb = 6'h00;
   wire         kick_single = stb[0], kick_first = stb[1], kick_second = stb[2];
   wire         halt_exec = stb[3], wake = stb[4], alu_flags_we = stb[5];
   localparam logic [5:0] st_single = 6'h01, st_first = 6'h02, st_second = 6'h04;
   localparam logic [5:0] st_halt = 6'h08, st_wake = 6'h10, st_flags = 6'h20;
   logic [3:0]  alu_flags = 4'h0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, q;
   logic        pready, pslverr, chip_reset, warm_reset, sys_clk_stop, irq, e;
   int          miscompares = 0, samples_checked = 0, cyc = 0, n, x;
   wdg_row_t    rows[7] = '{
      '{12'h024, 32'hFA, 32'hFA, 1'b0}, '{12'h024, 32'h00, 32'h00, 1'b0},
      '{12'h028, 32'hFF, 32'h0F, 1'b0}, '{12'h044, 32'h03, 32'h03, 1'b0},
      '{12'h04C, 32'hFF, 32'h01, 1'b0}, '{12'h030, 32'h55, 32'h00, 1'b1},
      '{12'h048, 32'h03, 32'h03, 1'b0}};

   wdg_top DUT (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .external_clear_n(external_clear_n), .wdg_osc(wdg_osc),
      .kick_single(kick_single), .kick_first(kick_first), .kick_second(kick_second),
      .halt_exec(halt_exec), .wake(wake), .alu_flags(alu_flags),
      .alu_flags_we(alu_flags_we), .chip_reset(chip_reset), .warm_reset(warm_reset),
      .sys_clk_stop(sys_clk_stop), .irq(irq));

   always #5 pclk = ~pclk;
   // rc oscillator, phase unrelated to pclk
   always #41 wdg_osc = ~wdg_osc;

   always @(posedge pclk)
   begin
      cyc++;
      if (cyc == 100000)
      begin
         miscompares++;
         finish_test();
      end
   end

   task finish_test();
      $display("compares %0d mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   task chk(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel    <= 1'b1;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   task pulse(input logic [5:0] m);
      @(posedge pclk);
      stb <= m;
      @(posedge pclk);
      stb <= 6'h00;
   endtask

   // cycles until a reset pulse, or lim if none came
   task wait_rst(input int lim, output int k);
      k = 0;
      while (k < lim && chip_reset !== 1'b1 && warm_reset !== 1'b1)
      begin
         @(posedge pclk);
         #1;
         k++;
      end
   endtask

   task idle(input int k);
      repeat (k) @(posedge pclk);
      #1;
   endtask

   initial
   begin
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      idle(2);
      apb(1'b0, 12'h024, 32'h0);
      chk(q, 32'h07);
      apb(1'b0, 12'h048, 32'h0);
      chk(q, 32'h01);
      apb(1'b0, 12'h028, 32'h0);
      chk(q & 32'h30, 32'h00);
      foreach (rows[i])
      begin
         apb(1'b1, rows[i].a, rows[i].d);
         apb(1'b0, rows[i].a, 32'h0);
         chk(q, rows[i].e);
         chk({31'h0, e}, {31'h0, rows[i].err});
      end
      alu_flags <= 4'h5;
      pulse(st_flags);
      apb(1'b0, 12'h028, 32'h0);
      chk(q, 32'h05);
      // instruction-clock source: 2048 cycles times 2^sel
      for (int s = 0; s < 3; s++)
      begin
         apb(1'b1, 12'h024, s);
         pulse(st_single);
         wait_rst(20000, n);
         x = 2048 << s;
         chk({31'h0, n >= x - 8 && n <= x + 12}, 32'h1);
         chk({31'h0, chip_reset}, 32'h1);
         idle(2);
         chk({31'h0, irq}, 32'h1);
         apb(1'b0, 12'h028, 32'h0);
         chk(q, 32'h25);
         apb(1'b0, 12'h040, 32'h0);
         chk(q, 32'h01);
         idle(1);
         chk({31'h0, irq}, 32'h0);
      end
      apb(1'b1, 12'h024, 32'h0);
      pulse(st_single);
      apb(1'b0, 12'h028, 32'h0);
      chk(q, 32'h05);
      repeat (3)
      begin
         wait_rst(1500, n);
         chk(n, 1500);
         pulse(st_single);
      end
      // single mode: the paired kicks do not clear
      idle(1000);
      pulse(st_first | st_second);
      pulse(st_first);
      pulse(st_second);
      wait_rst(2000, n);
      chk({31'h0, n > 900 && n < 1100}, 32'h1);
      apb(1'b0, 12'h040, 32'h0);
      chk(q, 32'h01);
      // time-out reloaded the select register
      apb(1'b1, 12'h024, 32'h0);
      // paired mode: single and lone first kicks do not clear
      apb(1'b1, 12'h048, 32'h07);
      pulse(st_first);
      pulse(st_second);
      repeat (3)
      begin
         idle(600);
         pulse(st_single);
         pulse(st_first);
      end
      wait_rst(2000, n);
      chk({31'h0, n < 400}, 32'h1);
      apb(1'b0, 12'h040, 32'h0);
      chk(q, 32'h01);
      apb(1'b1, 12'h024, 32'h0);
      pulse(st_first);
      pulse(st_second);
      wait_rst(1500, n);
      chk(n, 1500);
      // halt with instruction source: counting stops
      apb(1'b1, 12'h048, 32'h03);
      pulse(st_single);
      pulse(st_halt);
      idle(2);
      chk({31'h0, sys_clk_stop}, 32'h1);
      apb(1'b0, 12'h028, 32'h0);
      chk(q, 32'h15);
      wait_rst(5000, n);
      chk(n, 5000);
      pulse(st_wake);
      idle(2);
      chk({31'h0, sys_clk_stop}, 32'h0);
      // halt with rc source: overflow gives warm reset
      apb(1'b1, 12'h048, 32'h01);
      pulse(st_single);
      pulse(st_halt);
      wait_rst(6000, n);
      chk({31'h0, n >= 4170 && n <= 4230}, 32'h1);
      chk({31'h0, warm_reset, chip_reset}, 32'h2);
      idle(2);
      apb(1'b0, 12'h028, 32'h0);
      chk(q, 32'h35);
      apb(1'b0, 12'h040, 32'h0);
      chk(q, 32'h02);
      pulse(st_wake);
      // disabled: kick and halt leave flags alone
      apb(1'b1, 12'h048, 32'h00);
      pulse(st_single);
      pulse(st_halt);
      apb(1'b0, 12'h028, 32'h0);
      chk(q, 32'h35);
      pulse(st_wake);
      // external clear restarts the chain and reloads the select
      apb(1'b1, 12'h048, 32'h03);
      apb(1'b1, 12'h024, 32'h01);
      pulse(st_single);
      idle(3000);
      external_clear_n <= 1'b0;
      idle(4);
      external_clear_n <= 1'b1;
      idle(4);
      apb(1'b0, 12'h024, 32'h0);
      chk(q, 32'h07);
      apb(1'b1, 12'h024, 32'h00);
      wait_rst(1500, n);
      chk(n, 1500);
      // power-up reset mid-run clears the flags set by halt
      pulse(st_halt);
      @(posedge pclk);
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      idle(2);
      chk({31'h0, sys_clk_stop}, 32'h0);
      apb(1'b0, 12'h028, 32'h0);
      chk(q, 32'h00);
      finish_test();
   end
endmodule // tb_top
